// File: core/e1fr_core.sv
// Functional notes
// RULE1: ten-bit crc error count, snapshot every second
// RULE2: own exact one-second interval for snapshot
// RULE3: refreshed flag set on transfer, read clears
// RULE4: overrun flag when unread count overwritten
// RULE5: all registers cleared unless framed e1; the code keeps the mode and bus registers
// RULE6: ts16 frame 0 positions 5-8 to bits 5:2
// RULE7: ts16 bits refreshed on nfas frame pulse
// RULE8: ts16 and count frozen while out of frame
// RULE9: select code picks sa4..sa8 nibble source
// RULE10: first received value in bit 3
// RULE11: change flag against value at last read
// RULE12: enabled change flag pulls interrupt low
// RULE13: software leaves enable off for hdlc bits
// RULE14: offline frame loss change raises interrupt
// RULE15: rai with continuous crc raises interrupt
// RULE16: continuous far-end errors raise interrupt
// RULE17: link id in sa7 raises interrupt
// RULE18: basic frame pulse flag raises interrupt
// RULE19: crc submultiframe pulse flag raises interrupt
// RULE20: basic frame flag set every frame
// RULE21: submultiframe flag set at frame 0
// RULE22: second is 8000 frames of 125 us
// RULE23: interrupt is or of enabled set flags
//
// The implementer's own choice: the AHB-Lite register port.
`default_nettype none
module e1fr_core
	import e1fr_pkg::*;
#(
	parameter int FRAMES = FRAMES_PER_SEC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire e1fr_rx_t    rx,
	output logic             interrupt_out_n
);

	typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD, BUS_RDOUT} e1fr_bus_t;

	function automatic logic [3:0] sel_nibble(input logic [2:0] sel,
		input logic [19:0] nib);
		case (sel)
			SEL_SA4: sel_nibble = nib[19:16];
			SEL_SA5: sel_nibble = nib[15:12];
			SEL_SA6: sel_nibble = nib[11:8];
			SEL_SA7: sel_nibble = nib[7:4];
			SEL_SA8: sel_nibble = nib[3:0];
			default: sel_nibble = 4'h0;
		endcase
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
		hit = (a == idx);
	endfunction

	e1fr_bus_t         bus_q;
	e1fr_bus_t         bus_d;
	logic [7:0]        addr_q;
	logic [31:0]       hrdata_q;
	logic [1:0]        mode_q;
	logic [7:0]        nat_en_q;
	logic [7:0]        fp_en_q;
	logic [7:0]        fp_flg_q;
	logic [7:0]        fp_flg_d;
	logic [4:0]        nat_flg_q;
	logic [4:0]        nat_flg_d;
	logic [CNT_W-1:0]  err_acc_q;
	logic [CNT_W-1:0]  cnt_hold_q;
	logic [13:0]       frame_cnt_q;
	logic              new_q;
	logic              overrun_q;
	logic [3:0]        ts16_pend_q;
	logic [3:0]        ts16_q;
	logic [19:0]       shift_q;
	logic [19:0]       cand_q;
	logic [19:0]       deb_q;
	logic [19:0]       seen_q;
	logic [19:0]       seen_d;
	logic              ooof_prev_q;
	logic              v52_prev_q;
	logic              irq_n_q;

	// bus decode
	wire logic        accept   = hsel & htrans[1] & hready;
	wire logic [7:0]  a_idx    = haddr[9:2];
	wire logic        wr_phase = (bus_q == BUS_WR);
	wire logic        rd_phase = (bus_q == BUS_RD);
	wire logic        wr_mode  = wr_phase & hit(addr_q, IDX_MODE);
	wire logic        wr_naten = wr_phase & hit(addr_q, IDX_NAT_EN);
	wire logic        wr_fpen  = wr_phase & hit(addr_q, IDX_FP_EN);
	wire logic        rd_hi    = rd_phase & hit(addr_q, IDX_CNT_HI);
	wire logic        rd_natf  = rd_phase & hit(addr_q, IDX_NAT_FLG);
	wire logic        rd_fpf   = rd_phase & hit(addr_q, IDX_FP_FLG);

	// framed e1 only; otherwise everything below except the bus and mode registers sits in reset
	wire logic mode_clr = ~mode_q[MODE_E1] | mode_q[MODE_NOFRAME]; // see RULE5

	// one-second base from the frame stream, not the bus clock
	wire logic sec_tick = rx.frame_pulse &
		(frame_cnt_q == 14'(FRAMES - 1)); // see RULE22
	// transfer skipped while out of frame, count keeps running
	wire logic sec_xfer = sec_tick & ~rx.oof; // see RULE8
	wire logic ts16_upd = rx.frame_pulse & rx.nfas & ~rx.oof; // see RULE7
	wire logic nfas_fp  = rx.frame_pulse & rx.nfas;
	wire logic smf_end  = rx.smf_pulse;

	wire logic [CNT_W-1:0] acc_inc = (&err_acc_q) ? err_acc_q :
		err_acc_q + CNT_W'(1);

	wire logic [2:0] nat_sel = nat_en_q[7:NAT_SEL_LSB];
	wire logic [3:0] nat_val = sel_nibble(nat_sel, deb_q); // see RULE9

	wire logic [7:0] reg_hi = {overrun_q, new_q, ts16_q,
		cnt_hold_q[9:8]}; // see RULE1
	wire logic [7:0] rd_byte =
		hit(addr_q, IDX_CNT_LO)  ? cnt_hold_q[7:0] :
		hit(addr_q, IDX_CNT_HI)  ? reg_hi :
		hit(addr_q, IDX_NAT_EN)  ? nat_en_q :
		hit(addr_q, IDX_NAT_FLG) ? {3'h0, nat_flg_q} :
		hit(addr_q, IDX_NAT_VAL) ? {4'h0, nat_val} : // see RULE10
		hit(addr_q, IDX_FP_EN)   ? fp_en_q :
		hit(addr_q, IDX_FP_FLG)  ? fp_flg_q :
		hit(addr_q, IDX_MODE)    ? {6'h00, mode_q} :
		RST_BYTE;

	// national bit debounce: a nibble must repeat to be taken
	logic [4:0] nib_upd;
	logic [4:0] nib_set;
	always_comb begin
		seen_d = rd_natf ? deb_q : seen_q;
		for (int i = 0; i < 5; i++) begin
			nib_upd[i] = smf_end &
				(shift_q[i*4 +: 4] == cand_q[i*4 +: 4]) &
				(shift_q[i*4 +: 4] != deb_q[i*4 +: 4]);
			nib_set[i] = nib_upd[i] &
				(shift_q[i*4 +: 4] != seen_d[i*4 +: 4]); // see RULE11
		end
	end

	// flags: a set in the read cycle survives the clear
	assign nat_flg_d = (nat_flg_q & {5{~rd_natf}}) | nib_set;
	always_comb begin
		fp_flg_d = fp_flg_q & {8{~rd_fpf}};
		fp_flg_d[FP_OOOF]    = fp_flg_d[FP_OOOF] |
			(rx.ooof ^ ooof_prev_q);
		fp_flg_d[FP_RAICCRC] = fp_flg_d[FP_RAICCRC] | rx.raiccrc;
		fp_flg_d[FP_CFEBE]   = fp_flg_d[FP_CFEBE] | rx.cfebe;
		fp_flg_d[FP_V52]     = fp_flg_d[FP_V52] |
			(rx.v52link ^ v52_prev_q);
		fp_flg_d[FP_BRFP]    = fp_flg_d[FP_BRFP] |
			rx.frame_pulse; // see RULE20
		fp_flg_d[FP_ICSMFP]  = fp_flg_d[FP_ICSMFP] |
			rx.smf_pulse; // see RULE21
		fp_flg_d[FP_ICMFP]   = fp_flg_d[FP_ICMFP] | rx.cmf_pulse;
		fp_flg_d[FP_ISMFP]   = fp_flg_d[FP_ISMFP] | rx.sigmf_pulse;
	end

	// one term per enabled flag; hdlc-carrying sa bits left disabled
	wire logic irq_any = |(fp_flg_q & fp_en_q) |
		|(nat_flg_q & nat_en_q[4:0]); // see RULE12 see RULE14 see RULE23

	// bus state machine; reads take one wait state so data is a flop
	always_comb begin
		bus_d = bus_q;
		case (bus_q)
			BUS_RD:  bus_d = BUS_RDOUT;
			BUS_IDLE,
			BUS_WR,
			BUS_RDOUT: begin
				if (accept)
					bus_d = hwrite ? BUS_WR : BUS_RD;
				else
					bus_d = BUS_IDLE;
			end
			default: bus_d = BUS_IDLE;
		endcase
	end

	assign hreadyout = (bus_q != BUS_RD);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign interrupt_out_n = irq_n_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q    <= BUS_IDLE;
			addr_q   <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			bus_q <= bus_d;
			if (accept && hreadyout)
				addr_q <= a_idx;
			if (rd_phase)
				hrdata_q <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mode_q <= RST_MODE;
		else if (wr_mode)
			mode_q <= hwdata[1:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nat_en_q <= RST_BYTE;
			fp_en_q  <= RST_BYTE;
		end else if (mode_clr) begin
			nat_en_q <= RST_BYTE;
			fp_en_q  <= RST_BYTE;
		end else begin
			if (wr_naten)
				nat_en_q <= hwdata[7:0];
			if (wr_fpen)
				fp_en_q <= hwdata[7:0]; // see RULE15 see RULE16 see RULE17
		end
	end

	// error count and its once-a-second snapshot
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_cnt_q <= 14'h0000;
			err_acc_q   <= 10'h000;
			cnt_hold_q  <= 10'h000;
			new_q       <= 1'b0;
			overrun_q   <= 1'b0;
		end else if (mode_clr) begin
			frame_cnt_q <= 14'h0000;
			err_acc_q   <= 10'h000;
			cnt_hold_q  <= 10'h000;
			new_q       <= 1'b0;
			overrun_q   <= 1'b0;
		end else begin
			if (rx.frame_pulse)
				frame_cnt_q <= sec_tick ? 14'h0000 :
					frame_cnt_q + 14'h0001;
			if (sec_tick)
				err_acc_q <= rx.crc_error ? 10'h001 : 10'h000; // see RULE2
			else if (rx.crc_error)
				err_acc_q <= acc_inc;
			if (sec_xfer)
				cnt_hold_q <= rx.crc_error ? acc_inc : err_acc_q; // see RULE1
			new_q <= sec_xfer | (new_q & ~rd_hi); // see RULE3
			overrun_q <= (sec_xfer & new_q & ~rd_hi) |
				(overrun_q & ~rd_hi); // see RULE4
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ts16_pend_q <= 4'h0;
			ts16_q      <= 4'h0;
		end else if (mode_clr) begin
			ts16_pend_q <= 4'h0;
			ts16_q      <= 4'h0;
		end else begin
			if (rx.ts16_valid)
				ts16_pend_q <= rx.ts16_bits;
			if (ts16_upd)
				ts16_q <= ts16_pend_q; // see RULE6
		end
	end

	// nibble shift: first nfas value ends in bit 3
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q <= 20'h0_0000;
			cand_q  <= 20'h0_0000;
			deb_q   <= 20'h0_0000;
			seen_q  <= 20'h0_0000;
		end else if (mode_clr) begin
			shift_q <= 20'h0_0000;
			cand_q  <= 20'h0_0000;
			deb_q   <= 20'h0_0000;
			seen_q  <= 20'h0_0000;
		end else begin
			seen_q <= seen_d;
			if (smf_end)
				cand_q <= shift_q;
			for (int i = 0; i < 5; i++) begin
				if (nfas_fp)
					shift_q[i*4 +: 4] <= {shift_q[i*4 +: 3],
						rx.sa_bits[i]}; // see RULE10
				if (nib_upd[i])
					deb_q[i*4 +: 4] <= shift_q[i*4 +: 4];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nat_flg_q   <= 5'h00;
			fp_flg_q    <= RST_BYTE;
			ooof_prev_q <= 1'b0;
			v52_prev_q  <= 1'b0;
			irq_n_q     <= 1'b1;
		end else if (mode_clr) begin
			nat_flg_q   <= 5'h00;
			fp_flg_q    <= RST_BYTE;
			ooof_prev_q <= 1'b0;
			v52_prev_q  <= 1'b0;
			irq_n_q     <= 1'b1;
		end else begin
			nat_flg_q   <= nat_flg_d; // see RULE11
			fp_flg_q    <= fp_flg_d; // see RULE18 see RULE19
			ooof_prev_q <= rx.ooof;
			v52_prev_q  <= rx.v52link;
			irq_n_q     <= ~irq_any; // see RULE23
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_refresh_set: assert property ( // see RULE3
		sec_xfer && !mode_clr |=> new_q)
		else $error("refreshed flag not set on transfer");

	a_overrun_set: assert property ( // see RULE4
		sec_xfer && new_q && !rd_hi && !mode_clr |=> overrun_q)
		else $error("overrun flag not set on unread transfer");

	a_read_clears: assert property ( // see RULE3
		rd_hi && !sec_xfer && !mode_clr |=> !new_q && !overrun_q)
		else $error("count flags not cleared by read");

	a_mode_hold: assert property ( // see RULE5
		mode_clr |=> fp_en_q == 8'h00 && cnt_hold_q == 10'h000
			&& nat_flg_q == 5'h00)
		else $error("registers not held in mode reset");

	a_oof_freeze: assert property ( // see RULE8
		(rx.oof && !mode_clr) ##1 !mode_clr |->
			$stable(ts16_q) && $stable(cnt_hold_q))
		else $error("capture changed while out of frame");

	a_err_count: assert property ( // see RULE1
		rx.crc_error && !sec_tick && !mode_clr && err_acc_q < 10'h3FF
		|=> err_acc_q == $past(err_acc_q) + 10'h001)
		else $error("crc error not counted");

	a_brfp_set: assert property ( // see RULE20
		rx.frame_pulse && !mode_clr |=> fp_flg_q[FP_BRFP])
		else $error("basic frame flag not set");

	a_irq_follow: assert property ( // see RULE12
		irq_any && !mode_clr ##1 !mode_clr |-> !interrupt_out_n ##1
			(interrupt_out_n == !$past(irq_any)))
		else $error("interrupt output does not follow flags");

	a_sel_sa4: assert property ( // see RULE9
		nat_en_q[7:5] == SEL_SA4 |-> nat_val == deb_q[19:16])
		else $error("select code does not pick sa4");

	a_smf_set: assert property ( // see RULE21
		rx.smf_pulse && !mode_clr |=> fp_flg_q[FP_ICSMFP])
		else $error("submultiframe flag not set");

	a_ts16_take: assert property ( // see RULE7
		ts16_upd && !mode_clr |=> ts16_q == $past(ts16_pend_q))
		else $error("ts16 bits not taken on frame pulse");

endmodule
`default_nettype wire

// File: core/e1fr_pkg.sv
`default_nettype none
package e1fr_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CNT_LO  = 8'h99;
	localparam logic [7:0] IDX_CNT_HI  = 8'h9A;
	localparam logic [7:0] IDX_NAT_EN  = 8'h9B;
	localparam logic [7:0] IDX_NAT_FLG = 8'h9C;
	localparam logic [7:0] IDX_NAT_VAL = 8'h9D;
	localparam logic [7:0] IDX_FP_EN   = 8'h9E;
	localparam logic [7:0] IDX_FP_FLG  = 8'h9F;
	localparam logic [7:0] IDX_MODE    = 8'hA0;

	// field positions
	localparam int HI_OVERRUN   = 7;
	localparam int HI_NEW       = 6;
	localparam int HI_TS16_LSB  = 2;
	localparam int NAT_SEL_LSB  = 5;
	localparam int FP_OOOF      = 7;
	localparam int FP_RAICCRC   = 6;
	localparam int FP_CFEBE     = 5;
	localparam int FP_V52       = 4;
	localparam int FP_BRFP      = 3;
	localparam int FP_ICSMFP    = 2;
	localparam int FP_ICMFP     = 1;
	localparam int FP_ISMFP     = 0;
	localparam int MODE_E1      = 0;
	localparam int MODE_NOFRAME = 1;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_MODE = 2'h0;

	// national bit select codes
	localparam logic [2:0] SEL_SA4 = 3'h4;
	localparam logic [2:0] SEL_SA5 = 3'h5;
	localparam logic [2:0] SEL_SA6 = 3'h6;
	localparam logic [2:0] SEL_SA7 = 3'h7;
	localparam logic [2:0] SEL_SA8 = 3'h0;

	// timing: the second is counted in received frames
	localparam int FRAME_US       = 125;
	localparam int SECOND_US      = 1000000;
	localparam int FRAMES_PER_SEC = SECOND_US / FRAME_US;
	localparam int CNT_W          = 10;

	// events from the receive framer, same clock
	typedef struct packed {
		logic       frame_pulse;  // ts1 bit 1 of every frame
		logic       nfas;         // qualifies frame_pulse
		logic       smf_pulse;    // crc submultiframe frame 0
		logic       cmf_pulse;    // crc multiframe frame 0
		logic       sigmf_pulse;  // signalling multiframe
		logic       crc_error;
		logic       oof;
		logic       ts16_valid;   // ts16 of sig. mf frame 0 seen
		logic [3:0] ts16_bits;    // positions 5..8
		logic [4:0] sa_bits;      // [4]=sa4 .. [0]=sa8
		logic       ooof;
		logic       raiccrc;
		logic       cfebe;
		logic       v52link;
	} e1fr_rx_t;

endpackage
`default_nettype wire

// File: sim/tb.sv
`default_nettype none
module tb
	import e1fr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// short second keeps the run small
	localparam int FR = 8;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        interrupt_out_n;
	e1fr_rx_t    rx;
	e1fr_rx_t    lvl;
	logic [3:0]  ts;
	int          mismatches;
	int          comparisons;
	logic [4:0]  f [4] = '{5'h15, 5'h0C, 5'h1A, 5'h07};
	logic [2:0]  code [5] = '{SEL_SA4, SEL_SA5, SEL_SA6, SEL_SA7, SEL_SA8};
	logic [5:0]  kk [4] = '{6'h00, 6'h10, 6'h20, 6'h00};

	e1fr_core #(.FRAMES(FR)) e1fr_core_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .rx(rx),
		.interrupt_out_n(interrupt_out_n)
	);

	always #25 hclk = ~hclk;

	task automatic results();
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				mismatches++;
				results();
			end
			@(posedge hclk);
		end
	endtask

	task automatic bus(input logic [7:0] idx, input logic w,
			input logic [7:0] wd, output logic [31:0] rv);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {22'h0, idx, 2'h0};
		wait_rdy();
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= {24'h0, wd};
		wait_rdy();
		rv = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] x;
		bus(idx, 1'b1, d, x);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] x;
		bus(idx, 1'b0, 8'h00, x);
		check(x, {24'h0, e});
	endtask

	// k = {cfebe, raiccrc, smf, crc error, ts16 valid, nfas frame}
	task automatic pulse(input logic [5:0] k, input logic [4:0] sa);
		e1fr_rx_t v;
		v = lvl;
		v.frame_pulse = k[0];
		v.nfas = k[0];
		v.ts16_valid = k[1];
		v.ts16_bits = ts;
		v.crc_error = k[2];
		v.smf_pulse = k[3];
		v.raiccrc = k[4];
		v.cfebe = k[5];
		v.sa_bits = sa;
		rx <= v;
		@(posedge hclk);
		rx <= lvl;
		@(posedge hclk);
	endtask

	task automatic frames(input int n);
		repeat (n) pulse(6'h01, 5'h00);
	endtask

	task automatic round();
		for (int i = 0; i < 4; i++) pulse(6'h01, f[i]);
		pulse(6'h08, 5'h00);
	endtask

	function automatic logic [7:0] nib(input int k);
		return {4'h0, f[0][k], f[1][k], f[2][k], f[3][k]};
	endfunction

	task automatic irq(input logic e);
		@(posedge hclk);
		check({31'h0, interrupt_out_n}, {31'h0, e});
	endtask

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		rx = '0;
		lvl = '0;
		ts = 4'h0;
		mismatches = 0;
		comparisons = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		wr(IDX_FP_EN, 8'hFF);
		rd(IDX_FP_EN, 8'h00);
		wr(IDX_MODE, 8'h01);
		rd(IDX_NAT_EN, 8'h00);
		rd(IDX_FP_EN, 8'h00);
		wr(IDX_NAT_VAL, 8'hFF);
		rd(IDX_NAT_VAL, 8'h00);
		rd(8'h10, 8'h00);
		ts = 4'hA;
		repeat (3) pulse(6'h04, 5'h00);
		pulse(6'h02, 5'h00);
		frames(FR);
		rd(IDX_CNT_LO, 8'h03);
		rd(IDX_CNT_HI, 8'h68);
		rd(IDX_CNT_HI, 8'h28);
		frames(2 * FR);
		rd(IDX_CNT_LO, 8'h00);
		rd(IDX_CNT_HI, 8'hE8);
		// more than a byte of errors reaches the top two bits
		repeat (260) pulse(6'h04, 5'h00);
		frames(FR);
		rd(IDX_CNT_LO, 8'h04);
		rd(IDX_CNT_HI, 8'h69);
		// out of frame: no capture, no snapshot
		lvl.oof = 1'b1;
		ts = 4'h5;
		pulse(6'h06, 5'h00);
		frames(FR);
		rd(IDX_CNT_HI, 8'h29);
		lvl.oof = 1'b0;
		wr(IDX_NAT_EN, {SEL_SA5, 5'h08});
		repeat (3) round();
		rd(IDX_NAT_VAL, nib(3));
		irq(1'b0);
		rd(IDX_NAT_FLG, 8'h1F);
		irq(1'b1);
		round();
		rd(IDX_NAT_FLG, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(IDX_NAT_EN, {code[i], 5'h00});
			rd(IDX_NAT_VAL, nib(4 - i));
		end
		wr(IDX_NAT_EN, 8'h20);
		rd(IDX_NAT_VAL, 8'h00);
		rd(IDX_FP_FLG, 8'h0C);
		wr(IDX_FP_EN, 8'h08);
		frames(1);
		irq(1'b0);
		rd(IDX_FP_FLG, 8'h08);
		irq(1'b1);
		wr(IDX_FP_EN, 8'h04);
		pulse(6'h08, 5'h00);
		irq(1'b0);
		rd(IDX_FP_FLG, 8'h04);
		for (int j = 0; j < 4; j++) begin
			wr(IDX_FP_EN, 8'h80 >> j);
			if (j == 0) lvl.ooof = 1'b1;
			if (j == 3) lvl.v52link = 1'b1;
			pulse(kk[j], 5'h00);
			irq(1'b0);
			rd(IDX_FP_FLG, 8'h80 >> j);
		end
		wr(IDX_FP_EN, 8'h03);
		rx.cmf_pulse   <= 1'b1;
		rx.sigmf_pulse <= 1'b1;
		@(posedge hclk);
		rx <= lvl;
		@(posedge hclk);
		irq(1'b0);
		rd(IDX_FP_FLG, 8'h03);
		wr(IDX_FP_EN, 8'hFF);
		wr(IDX_MODE, 8'h03);
		rd(IDX_FP_EN, 8'h00);
		rd(IDX_NAT_VAL, 8'h00);
		irq(1'b1);
		results();
	end
endmodule
`default_nettype wire
